// file: core/ssl_decode.sv
// Shared package and the registered four-state position decoder
package ssl_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;                          // 125 MHz clock
    localparam int unsigned TS_RES_NS     = 1000000;                    // 1 ms stamp step
    localparam int unsigned MS_CYCLES     = TS_RES_NS / CLK_PERIOD_NS;  // Cycles per ms
    // ----------------------------------------------------------------
    // Widths, depths and reset values
    // ----------------------------------------------------------------
    localparam int unsigned LOG_DEPTH = 12;                             // Operation log depth
    localparam int unsigned CNT_W     = 32;                             // Counter width
    localparam int unsigned NUM_CNT   = 4;                              // Operation counters
    localparam logic [31:0] CNT_RST   = 32'h0000_0000;                  // Counter reset value
    // Counter slots
    localparam int unsigned CNT_OPEN       = 0;
    localparam int unsigned CNT_CLOSE      = 1;
    localparam int unsigned CNT_OPEN_FAIL  = 2;
    localparam int unsigned CNT_CLOSE_FAIL = 3;
    // Indicator bit positions in the four-signal vector
    localparam int unsigned IND_OPEN  = 0;
    localparam int unsigned IND_CLOSE = 1;
    localparam int unsigned IND_BAD   = 2;
    localparam int unsigned IND_INTER = 3;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SSL_POS_INTER = 2'h0,
        SSL_POS_OPEN  = 2'h1,
        SSL_POS_CLOSE = 2'h2,
        SSL_POS_BAD   = 2'h3
    } ssl_pos_t;
    // Operation record event names
    typedef enum logic [1:0] {
        SSL_REC_OPEN       = 2'h0,
        SSL_REC_CLOSE      = 2'h1,
        SSL_REC_OPEN_FAIL  = 2'h2,
        SSL_REC_CLOSE_FAIL = 2'h3
    } ssl_rec_ev_t;
    // Indicator event, one bit per signal and polarity
    typedef struct packed {
        logic [3:0]  rise;   // Assert events
        logic [3:0]  fall;   // Deassert events
        logic [31:0] stamp;  // Millisecond stamp
    } ssl_event_t;
    // One operation record
    typedef struct packed {
        logic [31:0] stamp;       // Date and time in ms
        ssl_rec_ev_t event_name;  // Event name
        logic [31:0] open_time;   // Opening time in ms
        logic [31:0] close_time;  // Closing time in ms
        ssl_pos_t    obj_pos;     // Object position
        ssl_pos_t    cart_pos;    // Withdrawable cart position
        logic [3:0]  open_fail;   // Open failure cause
        logic [3:0]  close_fail;  // Close failure cause
        logic [2:0]  open_src;    // Open command source
        logic [2:0]  close_src;   // Close command source
        logic [3:0]  gen_status;  // Overall function state
    } ssl_rec_t;
    // ----------------------------------------------------------------
    // Shared decode
    // ----------------------------------------------------------------
    function automatic ssl_pos_t ssl_decode_pos(input logic op, input logic cl);
        case ({cl, op})
            2'h0:    ssl_decode_pos = SSL_POS_INTER;
            2'h1:    ssl_decode_pos = SSL_POS_OPEN;
            2'h2:    ssl_decode_pos = SSL_POS_CLOSE;
            default: ssl_decode_pos = SSL_POS_BAD;
        endcase
    endfunction
endpackage

module ssl_decode
(
    input  wire logic          clk,         // System clock
    input  wire logic          reset,       // Synchronous reset
    input  wire logic          open_in,     // Open contact, high when open
    input  wire logic          close_in,    // Closed contact, high when closed
    input  wire logic          single_mode, // Closed taken as inverse of open
    output ssl_pkg::ssl_pos_t  pos_r        // Registered position
);
    logic close_eff;  // Effective closed contact

    // Single-input monitoring derives closed from open
    assign close_eff = single_mode ? ~open_in : close_in;

    // Position register
    always_ff @(posedge clk)
    begin
        if (reset)
            pos_r <= ssl_pkg::SSL_POS_INTER;
        else
            pos_r <= ssl_pkg::ssl_decode_pos(open_in, close_eff);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_inter;
        !$past(open_in) && !$past(close_eff) |-> pos_r == ssl_pkg::SSL_POS_INTER;
    endproperty
    a_inter: assert property (p_inter) else $error("Intermediate not shown");
    property p_bad;
        !$past(reset) && $past(open_in) && $past(close_eff) |-> pos_r == ssl_pkg::SSL_POS_BAD;
    endproperty
    a_bad: assert property (p_bad) else $error("Bad not shown");
    property p_single;
        single_mode && $past(single_mode) |-> pos_r != ssl_pkg::SSL_POS_BAD;
    endproperty
    a_single: assert property (p_single) else $error("Single input gave bad");
endmodule // ssl_decode

// file: core/ssl_top.sv
// Switch position indicator, event stamping, operation counters and log
module ssl_top
#(
    parameter int unsigned MS_CYCLES = ssl_pkg::MS_CYCLES  // Cycles per millisecond
)
(
    input  wire logic               clk,             // System clock
    input  wire logic               reset,           // Synchronous reset
    input  wire logic               open_in,         // Open position contact
    input  wire logic               close_in,        // Closed position contact
    input  wire logic               cart_out_in,     // Cart withdrawn contact
    input  wire logic               cart_in_in,      // Cart inserted contact
    input  wire logic               mon_en,          // Monitoring running
    input  wire logic               cfg_load,        // Latch configuration
    input  wire logic               cfg_single,      // Single-input mode
    input  wire logic [7:0]         cfg_filter,      // [3:0] keep assert, [7:4] keep deassert
    input  wire logic               open_cmd,        // Open command accepted pulse
    input  wire logic [2:0]         open_src,        // Open command source
    input  wire logic               close_cmd,       // Close command accepted pulse
    input  wire logic [2:0]         close_src,       // Close command source
    input  wire logic               open_fail,       // Open command failed pulse
    input  wire logic [3:0]         open_cause,      // Open failure cause
    input  wire logic               close_fail,      // Close command failed pulse
    input  wire logic [3:0]         close_cause,     // Close failure cause
    input  wire logic [3:0]         gen_status,      // Overall function state
    input  wire logic [3:0]         cnt_clr,         // Counter clear pulses
    input  wire logic               wear_meas_done,  // Current measurement finished
    input  wire logic [31:0]        wear_ops_left,   // Operations left from wear calc
    input  wire logic [1:0]         wear_alarm,      // Wear alarms from wear calc
    input  wire logic [3:0]         rd_idx,          // Log read index, 0 newest
    output ssl_pkg::ssl_pos_t       obj_pos_r,       // Object position
    output ssl_pkg::ssl_pos_t       cart_pos_r,      // Cart position
    output logic                    ev_valid_r,      // Indicator event pulse
    output logic                    ev_store_r,      // Event goes to main buffer
    output ssl_pkg::ssl_event_t     ev_r,            // Event content
    output logic [4*32-1:0]         cnt_r,           // Counters, slot 0 lowest
    output logic [31:0]             open_time_r,     // Latest opening time
    output logic [31:0]             close_time_r,    // Latest closing time
    output logic [3:0]              log_cnt_r,       // Records held
    output logic                    rd_valid_r,      // Read record valid
    output ssl_pkg::ssl_rec_t       rd_rec_r,        // Read record
    output logic [31:0]             ops_left_r,      // Operations left
    output logic [1:0]              alarm_r          // Wear alarms
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam logic [3:0] DEPTH = 4'(ssl_pkg::LOG_DEPTH);  // Log depth at pointer width

    logic                 single_r;              // Latched single-input mode
    logic [7:0]           filter_r;              // Latched storage filter
    logic [31:0]          ms_div_r;              // Millisecond divider
    logic [31:0]          ts_r;                  // Millisecond time stamp
    logic                 ms_tick;               // One ms elapsed
    ssl_pkg::ssl_pos_t    pos;                   // Decoded object position
    logic [3:0]           ind;                   // Indicator signals
    logic [3:0]           ind_prev_r;            // Previous indicator signals
    logic [3:0]           rise, fall;            // Indicator edges
    logic                 open_busy_r;           // Open timing running
    logic                 close_busy_r;          // Close timing running
    logic [31:0]          open_tmr_r;            // Open elapsed ms
    logic [31:0]          close_tmr_r;           // Close elapsed ms
    logic                 open_done, close_done; // Operation completed
    logic                 meas_armed_r;          // Open seen, waiting for measurement
    logic [2:0]           osrc_r, csrc_r;        // Latest command sources
    ssl_pkg::ssl_rec_t    log_mem [ssl_pkg::LOG_DEPTH];  // Operation log
    logic [3:0]           wr_ptr_r;              // Next write slot
    logic                 rec_we;                // Write a record
    ssl_pkg::ssl_rec_t    rec_nxt;               // Record being written

    // Wrap an index into the log
    function automatic logic [3:0] wrap(input logic [4:0] v);
        wrap = (v >= 5'(DEPTH)) ? 4'(v - 5'(DEPTH)) : v[3:0];
    endfunction

    // ----------------------------------------------------------------
    // Configuration and time base
    // ----------------------------------------------------------------
    // Selections only load while monitoring is stopped
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            single_r <= 1'b0;
            filter_r <= 8'hFF;
        end
        else if (cfg_load && !mon_en)
        begin
            single_r <= cfg_single;
            filter_r <= cfg_filter;
        end
    end

    assign ms_tick = (ms_div_r == 32'(MS_CYCLES - 1));

    // Millisecond stamp counter
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ms_div_r <= 32'h0000_0000;
            ts_r     <= 32'h0000_0000;
        end
        else if (ms_tick)
        begin
            ms_div_r <= 32'h0000_0000;
            ts_r     <= ts_r + 32'h0000_0001;
        end
        else
            ms_div_r <= ms_div_r + 32'h0000_0001;
    end

    // ----------------------------------------------------------------
    // Position decode and indicator events
    // ----------------------------------------------------------------
    ssl_decode u_obj
    (
        .clk         (clk),
        .reset       (reset),
        .open_in     (open_in),
        .close_in    (close_in),
        .single_mode (single_r),
        .pos_r       (pos)
    );

    // Cart position uses the same decode
    always_ff @(posedge clk)
    begin
        if (reset)
            cart_pos_r <= ssl_pkg::SSL_POS_INTER;
        else
            cart_pos_r <= ssl_pkg::ssl_decode_pos(cart_out_in, cart_in_in);
    end

    assign ind[ssl_pkg::IND_OPEN]  = (pos == ssl_pkg::SSL_POS_OPEN);
    assign ind[ssl_pkg::IND_CLOSE] = (pos == ssl_pkg::SSL_POS_CLOSE);
    assign ind[ssl_pkg::IND_BAD]   = (pos == ssl_pkg::SSL_POS_BAD);
    assign ind[ssl_pkg::IND_INTER] = (pos == ssl_pkg::SSL_POS_INTER);
    assign rise = ind & ~ind_prev_r;
    assign fall = ~ind & ind_prev_r;

    // Event output with time stamp and storage filter
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ind_prev_r <= 4'h8;
            obj_pos_r  <= ssl_pkg::SSL_POS_INTER;
            ev_valid_r <= 1'b0;
            ev_store_r <= 1'b0;
            ev_r       <= '0;
        end
        else
        begin
            ind_prev_r <= ind;
            obj_pos_r  <= pos;
            ev_valid_r <= |(rise | fall);
            ev_store_r <= |((rise & filter_r[3:0]) | (fall & filter_r[7:4]));
            ev_r       <= '{rise: rise, fall: fall, stamp: ts_r};
        end
    end

    // ----------------------------------------------------------------
    // Operation timing; the block only watches commands, never issues any
    // ----------------------------------------------------------------
    assign open_done  = open_busy_r && (pos == ssl_pkg::SSL_POS_OPEN);
    assign close_done = close_busy_r && (pos == ssl_pkg::SSL_POS_CLOSE);

    // Opening and closing timers in ms
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            open_busy_r  <= 1'b0;
            close_busy_r <= 1'b0;
            open_tmr_r   <= 32'h0000_0000;
            close_tmr_r  <= 32'h0000_0000;
            open_time_r  <= 32'h0000_0000;
            close_time_r <= 32'h0000_0000;
            osrc_r       <= 3'h0;
            csrc_r       <= 3'h0;
        end
        else
        begin
            if (open_cmd)
            begin
                open_busy_r <= 1'b1;
                open_tmr_r  <= 32'h0000_0000;
                osrc_r      <= open_src;
            end
            else if (open_done || open_fail)
            begin
                open_busy_r <= 1'b0;
                if (open_done)
                    open_time_r <= open_tmr_r;
            end
            else if (open_busy_r && ms_tick)
                open_tmr_r <= open_tmr_r + 32'h0000_0001;
            if (close_cmd)
            begin
                close_busy_r <= 1'b1;
                close_tmr_r  <= 32'h0000_0000;
                csrc_r       <= close_src;
            end
            else if (close_done || close_fail)
            begin
                close_busy_r <= 1'b0;
                if (close_done)
                    close_time_r <= close_tmr_r;
            end
            else if (close_busy_r && ms_tick)
                close_tmr_r <= close_tmr_r + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Cumulative counters
    // ----------------------------------------------------------------
    logic [3:0] cnt_inc;  // Count events per slot
    assign cnt_inc = {close_fail, open_fail, close_done, open_done};

    for (genvar g = 0; g < ssl_pkg::NUM_CNT; g++)
    begin : g_cnt
        // A count in the clear cycle survives as one
        always_ff @(posedge clk)
        begin
            if (reset)
                cnt_r[g*32 +: 32] <= ssl_pkg::CNT_RST;
            else if (cnt_clr[g])
                cnt_r[g*32 +: 32] <= cnt_inc[g] ? 32'h0000_0001 : ssl_pkg::CNT_RST;
            else if (cnt_inc[g])
                cnt_r[g*32 +: 32] <= cnt_r[g*32 +: 32] + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Operation log
    // ----------------------------------------------------------------
    assign rec_we = open_done | close_done | open_fail | close_fail;

    // Record assembly, completion ahead of failure
    always_comb
    begin
        rec_nxt = '{stamp: ts_r, event_name: ssl_pkg::SSL_REC_OPEN,
                    open_time: open_time_r, close_time: close_time_r,
                    obj_pos: pos, cart_pos: cart_pos_r,
                    open_fail: 4'h0, close_fail: 4'h0,
                    open_src: osrc_r, close_src: csrc_r,
                    gen_status: gen_status};
        if (open_done)
            rec_nxt.open_time = open_tmr_r;
        else if (close_done)
        begin
            rec_nxt.event_name = ssl_pkg::SSL_REC_CLOSE;
            rec_nxt.close_time = close_tmr_r;
        end
        else if (open_fail)
        begin
            rec_nxt.event_name = ssl_pkg::SSL_REC_OPEN_FAIL;
            rec_nxt.open_fail  = open_cause;
        end
        else
        begin
            rec_nxt.event_name = ssl_pkg::SSL_REC_CLOSE_FAIL;
            rec_nxt.close_fail = close_cause;
        end
    end

    // Ring of twelve; oldest slot is overwritten when full
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr_r  <= 4'h0;
            log_cnt_r <= 4'h0;
        end
        else if (rec_we)
        begin
            log_mem[wr_ptr_r] <= rec_nxt;
            wr_ptr_r          <= wrap({1'b0, wr_ptr_r} + 5'h01);
            if (log_cnt_r != DEPTH)
                log_cnt_r <= log_cnt_r + 4'h1;
        end
    end

    // Read port, index 0 is the newest record
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rd_valid_r <= 1'b0;
            rd_rec_r   <= '0;
        end
        else
        begin
            rd_valid_r <= (rd_idx < log_cnt_r);
            rd_rec_r   <= log_mem[wrap({1'b0, wr_ptr_r} + 5'(DEPTH) - 5'h01 - {1'b0, rd_idx})];
        end
    end

    // ----------------------------------------------------------------
    // Wear figures
    // ----------------------------------------------------------------
    // Only a measurement started by an open command refreshes them
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meas_armed_r <= 1'b0;
            ops_left_r   <= 32'h0000_0000;
            alarm_r      <= 2'h0;
        end
        else if (open_cmd)
            meas_armed_r <= 1'b1;
        else if (meas_armed_r && wear_meas_done)
        begin
            meas_armed_r <= 1'b0;
            ops_left_r   <= wear_ops_left;
            alarm_r      <= wear_alarm;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_open_start;
        open_cmd ##1 !open_cmd && !open_fail;
    endsequence
    property p_filter;
        ##1 ev_store_r == |(($past(rise) & $past(filter_r[3:0])) |
                            ($past(fall) & $past(filter_r[7:4])));
    endproperty
    a_filter: assert property (p_filter) else $error("Filter mismatch");
    property p_cnt;
        cnt_inc[0] && !cnt_clr[0] |=> cnt_r[31:0] == $past(cnt_r[31:0]) + 32'h0000_0001;
    endproperty
    a_cnt: assert property (p_cnt) else $error("Open counter not advanced");
    property p_clr;
        cnt_clr[1] && !cnt_inc[1] |=> cnt_r[63:32] == 32'h0000_0000;
    endproperty
    a_clr: assert property (p_clr) else $error("Close counter not cleared");
    property p_depth;
        log_cnt_r == DEPTH && rec_we |=> log_cnt_r == DEPTH;
    endproperty
    a_depth: assert property (p_depth) else $error("Log depth wrong");
    property p_open_time;
        s_open_start ##0 open_done |=> open_time_r == 32'h0000_0000;
    endproperty
    a_open_time: assert property (p_open_time) else $error("Opening time wrong");
    property p_close_rec;
        close_done && !open_done |=> log_cnt_r != 4'h0 && cnt_r[63:32] != 32'h0000_0000;
    endproperty
    a_close_rec: assert property (p_close_rec) else $error("Close not logged");
    property p_event;
        ind != ind_prev_r |=> ev_valid_r && ev_r.stamp == $past(ts_r);
    endproperty
    a_event: assert property (p_event) else $error("Indicator event missed");
    property p_stamp;
        ms_tick |=> ts_r == $past(ts_r) + 32'h0000_0001 && ms_div_r == 32'h0000_0000;
    endproperty
    a_stamp: assert property (p_stamp) else $error("Stamp step wrong");
    property p_cfg;
        mon_en && $past(mon_en) |-> $stable(single_r) && $stable(filter_r);
    endproperty
    a_cfg: assert property (p_cfg) else $error("Config changed while running");
    property p_wear;
        !(meas_armed_r && wear_meas_done) |=> $stable(ops_left_r) && $stable(alarm_r);
    endproperty
    a_wear: assert property (p_wear) else $error("Wear figure updated early");
endmodule // ssl_top

// file: bench/ssl_contacts.sv
// Behavioural switchgear contacts that follow a requested position
module ssl_contacts
(
    input  wire logic       clk,      // System clock
    input  wire logic [1:0] want,     // Requested contacts {closed, open}
    input  wire logic [7:0] lag,      // Travel time in cycles
    output logic            open_in,  // Open contact, high when open
    output logic            close_in  // Closed contact, high when closed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r = 8'h00;  // Travel counter
    initial {close_in, open_in} = 2'h0;
    // Contacts settle at a falling edge once the travel time has run out
    always @(negedge clk)
    begin
        if ({close_in, open_in} == want)
            cnt_r <= 8'h00;
        else if (cnt_r >= lag)
            {close_in, open_in} <= want;
        else
            cnt_r <= cnt_r + 8'h01;
    end
endmodule  // ssl_contacts

// file: bench/ssl_top_test.sv
// Bench for the position logger: decode, filter, timing, counters and log
module ssl_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned MSC = 4;  // Shortened millisecond
    logic              clk = 1'b0;    // System clock
    logic              reset = 1'b1;  // Synchronous reset
    logic              mon_en, cfg_load, cfg_single, open_cmd, close_cmd, open_fail, close_fail;
    logic              meas;          // Wear measurement pulse
    logic [7:0]        cfg_filter;    // Event filter
    logic [7:0]        lag;           // Contact travel time
    logic [3:0]        cnt_clr;       // Counter clears
    logic [3:0]        misc;          // Sources, causes and state
    logic [1:0]        want;          // Requested contacts
    logic              open_in, close_in;
    ssl_pkg::ssl_pos_t obj_pos_r;     // Decoded position
    logic              ev_store_r;    // Event stored flag
    ssl_pkg::ssl_event_t ev_r;        // Event content
    logic [127:0]      cnt_r;         // Counters
    logic [31:0]       open_time_r;   // Latest opening time
    logic [3:0]        log_cnt_r;     // Records held
    ssl_pkg::ssl_rec_t rd_rec_r;      // Newest record
    logic              ev_valid_r, rd_valid_r;    // Event and read valid
    ssl_pkg::ssl_pos_t cart_pos_r;    // Decoded cart position
    logic [31:0]       close_time_r, ops_left_r;  // Closing time, wear figure
    logic [1:0]        alarm_r;       // Wear alarms
    int                mismatches = 0;
    int                n_compared = 0;
    always #4 clk = ~clk;
    ssl_contacts u_ssl_contacts (.clk(clk), .want(want), .lag(lag), .open_in(open_in),
        .close_in(close_in));
    ssl_top #(.MS_CYCLES(MSC)) u_ssl_top (.clk(clk), .reset(reset), .open_in(open_in),
        .close_in(close_in), .cart_out_in(open_in), .cart_in_in(close_in), .mon_en(mon_en),
        .cfg_load(cfg_load), .cfg_single(cfg_single), .cfg_filter(cfg_filter),
        .open_cmd(open_cmd), .open_src(misc[2:0]), .close_cmd(close_cmd),
        .close_src(misc[2:0]), .open_fail(open_fail), .open_cause(misc),
        .close_fail(close_fail), .close_cause(misc), .gen_status(misc), .cnt_clr(cnt_clr),
        .wear_meas_done(meas), .wear_ops_left({8{misc}}), .wear_alarm(misc[1:0]),
        .rd_idx(4'h0), .obj_pos_r(obj_pos_r), .cart_pos_r(cart_pos_r),
        .ev_valid_r(ev_valid_r), .ev_store_r(ev_store_r), .ev_r(ev_r), .cnt_r(cnt_r),
        .open_time_r(open_time_r), .close_time_r(close_time_r), .log_cnt_r(log_cnt_r),
        .rd_valid_r(rd_valid_r), .rd_rec_r(rd_rec_r), .ops_left_r(ops_left_r),
        .alarm_r(alarm_r));
    // Compare one value and count it
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Move the contacts, then wait a bounded time for the decoded position
    task automatic move(input logic [1:0] w, input logic [1:0] p);
        int i;
        want = w;
        for (i = 0; i < 200 && obj_pos_r !== ssl_pkg::ssl_pos_t'(p); i++)
            tick(1);
        check(obj_pos_r, p);
        if (i == 200)
            final_report();
    endtask
    task automatic set_cfg(input logic s, input logic [7:0] f);
        cfg_single = s;
        cfg_filter = f;
        cfg_load = 1'b1;
        tick(1);
        cfg_load = 1'b0;
    endtask
    // One-hot of a contact pair in the event bit order
    function automatic logic [3:0] oh(input logic [1:0] w);
        return (w == 2'h0) ? 4'h8 : (w == 2'h1) ? 4'h1 : (w == 2'h2) ? 4'h2 : 4'h4;
    endfunction
    // Walk all states; a reload while monitoring runs must be ignored
    task automatic t_decode();
        logic [1:0] seq [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
        logic [3:0] prv = 4'h8;
        logic [7:0] ev;
        set_cfg(1'b0, 8'h81);
        mon_en = 1'b1;
        set_cfg(1'b0, 8'h00);
        foreach (seq[k])
        begin
            ev = {oh(seq[k]) & ~prv, prv & ~oh(seq[k])};
            move(seq[k], seq[k]);
            check(ev_r[39:32], ev);
            check(ev_store_r, |({ev[3:0], ev[7:4]} & 8'h81));
            check(ev_valid_r, 1'b1);
            check(cart_pos_r, seq[k]);
            prv = oh(seq[k]);
        end
        $display("test decode done");
    endtask
    // Single input: closed follows the inverse of open, closed contact ignored
    task automatic t_single();
        mon_en = 1'b0;
        set_cfg(1'b1, 8'hFF);
        move(2'h0, 2'h2);
        move(2'h3, 2'h1);
        set_cfg(1'b0, 8'hFF);
        move(2'h2, 2'h2);
        $display("test single done");
    endtask
    // Timed open and close, counts, records, counter clear, wear refresh
    task automatic t_open();
        lag = 8'h28;
        misc = 4'h5;
        meas = 1'b1;
        tick(1);
        meas = 1'b0;
        check({alarm_r, ops_left_r}, 34'h0);
        open_cmd = 1'b1;
        want = 2'h1;
        tick(1);
        open_cmd = 1'b0;
        move(2'h1, 2'h1);
        tick(2);
        check(open_time_r >= 32'h9 && open_time_r <= 32'hC, 1'b1);
        check(cnt_r[31:0], 32'h1);
        check(log_cnt_r, 4'h1);
        check(rd_rec_r.open_src, 3'h5);
        cnt_clr = 4'h1;
        tick(2);
        cnt_clr = 4'h0;
        check(cnt_r[31:0], 32'h0);
        open_cmd = 1'b1;
        tick(1);
        {open_cmd, meas} = 2'h1;
        tick(1);
        meas = 1'b0;
        check(open_time_r, 32'h0);
        check(cnt_r[31:0], 32'h1);
        check({alarm_r, ops_left_r}, {2'h1, 32'h5555_5555});
        close_cmd = 1'b1;
        want = 2'h2;
        tick(1);
        close_cmd = 1'b0;
        move(2'h2, 2'h2);
        tick(2);
        check(close_time_r >= 32'h9 && close_time_r <= 32'hC, 1'b1);
        check(cnt_r[63:32], 32'h1);
        check(rd_rec_r.event_name, ssl_pkg::SSL_REC_CLOSE);
        check(rd_valid_r, 1'b1);
        $display("test open done");
    endtask
    // Overfill the log with failures
    task automatic t_log();
        repeat (13)
        begin
            open_fail = 1'b1;
            tick(1);
            open_fail = 1'b0;
            tick(1);
        end
        tick(2);
        check(log_cnt_r, 4'hC);
        check(cnt_r[95:64], 32'hD);
        check(rd_rec_r.event_name, ssl_pkg::SSL_REC_OPEN_FAIL);
        $display("test log done");
    endtask
    initial
    begin
        {mon_en, cfg_load, cfg_single, open_cmd, close_cmd, open_fail, close_fail, meas} = '0;
        {cfg_filter, lag, cnt_clr, misc, want} = '0;
        tick(8);
        reset = 1'b0;
        tick(1);
        t_decode();
        t_single();
        t_open();
        t_log();
        final_report();
    end
endmodule  // ssl_top_test
